//--- pkg/bch_map.svh
// Register map of the bridge configuration header, dwords 08h to 1Fh.
// Assumes byte addresses on a 32-bit APB slave, one aligned word per register.
// Function
// (R1) Revision byte at 08h bits 7:0 is read-only; writes are ignored.
// (R2) Class code read-only: interface 00h, sub-class 04h, base class 06h.
// (R3) Cache line size bits 5:2 writable, reset zero: 4, 8, 16, 32 dwords.
// (R4) Cache line size bits 1:0 and 7:6 read zero and ignore writes.
// (R5) Primary latency timer at 0Ch bits 15:8 is read-only, reads 00h.
// (R6) Header type reads 0000001, bit 23 reads 0, bits 31:24 read 00h.
// (R7) Offsets 10h through 17h are reserved, nothing implemented there.
// (R8) Primary, secondary, subordinate bus numbers writable at 18h, reset 00h.
// (R9) Secondary latency timer writable at 18h bits 31:24, reset 00h.
// (R10) I/O base and limit capability bits read 01; bits 3:2, 11:10 read 00.
// (R11) I/O base nibble bits 7:4 writable, reset 0000, window start 0.
// (R12) I/O limit nibble bits 15:12 writable, reset 0000, window end 0FFFh.
// (R13) Reserved offsets and bits read zero; writes there have no effect.
`ifndef BCH_MAP_SVH
`define BCH_MAP_SVH

`define BCH_OFS_IDENT      8'h08
`define BCH_OFS_LINE       8'h0c
`define BCH_OFS_RSVD_LO    8'h10
`define BCH_OFS_RSVD_HI    8'h14
`define BCH_OFS_BUSNUM     8'h18
`define BCH_OFS_IOWIN      8'h1c

`define BCH_CLASS_PROGIF   8'h00
`define BCH_CLASS_SUB      8'h04
`define BCH_CLASS_BASE     8'h06
`define BCH_PRI_LATENCY    8'h00
`define BCH_HDR_LAYOUT     7'h01
`define BCH_HDR_MULTIFN    1'h0
`define BCH_HDR_RSVD       8'h00
`define BCH_IO_ADDR_CAP    2'h1
`define BCH_IO_RSVD        2'h0

`define BCH_LINE_LSB       2
`define BCH_LINE_MSB       5
`define BCH_IOBASE_LSB     4
`define BCH_IOLIMIT_LSB    12

`define BCH_RST_BYTE       8'h00
`define BCH_RST_NIBBLE     4'h0
`define BCH_IO_LOW_START   12'h000
`define BCH_IO_LOW_END     12'hfff

`endif

//--- pkg/bch_pkg.sv
// Types shared by the bridge configuration header registers.
// Assumes bch_map.svh supplies the numeric constants.
`default_nettype none

package bch_pkg;

    // Software-programmed settings that steer the bridge datapath.
    typedef struct packed {
        logic [7:0] primaryBus;
        logic [7:0] secondaryBus;
        logic [7:0] subordinateBus;
        logic [7:0] secLatency;
        logic [3:0] ioBase;
        logic [3:0] ioLimit;
        logic [3:0] lineSel;
    } bch_cfg_s;

endpackage

`default_nettype wire

//--- logic/bch_config_header_regs.sv
// APB register slave for configuration dwords 08h to 1Fh of a bridge.
// Assumes an APB master on sys_clk; the slave never inserts wait states.
`timescale 1ns/100ps
`default_nettype none
`include "bch_map.svh"

module bch_config_header_regs #(
    parameter logic [7:0] REV_CODE = 8'h01, // Arbitrary value, set per silicon step.
    parameter int         ADDR_W   = 8
) (
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    output var  bch_pkg::bch_cfg_s cfgOut,
    output var  logic [31:0]       ioWindowStart,
    output var  logic [31:0]       ioWindowEnd,
    output var  logic [5:0]        lineDwords
);

    // Maps the one-hot line size selection to a dword count, zero if none.
    function automatic logic [5:0] line_dwords(input logic [3:0] sel);
        logic [5:0] n;
        n = 6'h00;
        if (sel[3]) begin
            n = 6'h20;
        end else if (sel[2]) begin
            n = 6'h10;
        end else if (sel[1]) begin
            n = 6'h08;
        end else if (sel[0]) begin
            n = 6'h04;
        end
        return n;
    endfunction

    bch_pkg::bch_cfg_s cfg_q;
    bch_pkg::bch_cfg_s cfg_d;
    logic [31:0]       prdata_q;
    logic [31:0]       ioStart_q;
    logic [31:0]       ioEnd_q;
    logic [5:0]        lineDw_q;

    // Bus phase decode; zero wait states keep pready high at all times.
    wire logic       setupPh  = psel & ~penable;
    wire logic       wrAccess = psel & penable & pwrite;
    wire logic [7:0] ofs      = 8'(paddr) & 8'hfc;
    wire logic       hitIdent = (ofs == `BCH_OFS_IDENT);
    wire logic       hitLine  = (ofs == `BCH_OFS_LINE);
    wire logic       hitBus   = (ofs == `BCH_OFS_BUSNUM);
    wire logic       hitIo    = (ofs == `BCH_OFS_IOWIN);

    // Read images; unmapped and reserved offsets fall through to zero.
    wire logic [31:0] identWord = {`BCH_CLASS_BASE, `BCH_CLASS_SUB,
                                   `BCH_CLASS_PROGIF, REV_CODE}; // see (R1) (R2)
    wire logic [31:0] lineWord  = {`BCH_HDR_RSVD, `BCH_HDR_MULTIFN, `BCH_HDR_LAYOUT,
                                   `BCH_PRI_LATENCY,
                                   2'h0, cfg_q.lineSel, 2'h0}; // see (R3) (R4) (R5) (R6)
    wire logic [31:0] busWord   = {cfg_q.secLatency, cfg_q.subordinateBus,
                                   cfg_q.secondaryBus, cfg_q.primaryBus}; // see (R8) (R9)
    wire logic [31:0] ioWord    = {16'h0000, cfg_q.ioLimit, `BCH_IO_RSVD, `BCH_IO_ADDR_CAP,
                                   cfg_q.ioBase, `BCH_IO_RSVD, `BCH_IO_ADDR_CAP}; // see (R10)
    wire logic [31:0] rdMux     = hitIdent ? identWord :
                                  hitLine  ? lineWord  :
                                  hitBus   ? busWord   :
                                  hitIo    ? ioWord    : 32'h0000_0000; // see (R7) (R13)

    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign prdata  = prdata_q;
    assign cfgOut  = cfg_q;
    assign ioWindowStart = ioStart_q;
    assign ioWindowEnd   = ioEnd_q;
    assign lineDwords    = lineDw_q;

    // Next value of the writable fields; only the named byte lanes move.
    always_comb begin
        cfg_d = cfg_q;
        if (wrAccess && hitLine && pstrb[0]) begin
            cfg_d.lineSel = pwdata[`BCH_LINE_MSB:`BCH_LINE_LSB]; // see (R3) (R4)
        end
        if (wrAccess && hitBus) begin
            if (pstrb[0]) begin
                cfg_d.primaryBus = pwdata[7:0]; // see (R8)
            end
            if (pstrb[1]) begin
                cfg_d.secondaryBus = pwdata[15:8]; // see (R8)
            end
            if (pstrb[2]) begin
                cfg_d.subordinateBus = pwdata[23:16]; // see (R8)
            end
            if (pstrb[3]) begin
                cfg_d.secLatency = pwdata[31:24]; // see (R9)
            end
        end
        if (wrAccess && hitIo) begin
            if (pstrb[0]) begin
                cfg_d.ioBase = pwdata[`BCH_IOBASE_LSB+3:`BCH_IOBASE_LSB]; // see (R11)
            end
            if (pstrb[1]) begin
                cfg_d.ioLimit = pwdata[`BCH_IOLIMIT_LSB+3:`BCH_IOLIMIT_LSB]; // see (R12)
            end
        end
    end

    // Writable fields; every one clears at reset.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_q <= '{primaryBus: `BCH_RST_BYTE, secondaryBus: `BCH_RST_BYTE,
                       subordinateBus: `BCH_RST_BYTE, secLatency: `BCH_RST_BYTE,
                       ioBase: `BCH_RST_NIBBLE, ioLimit: `BCH_RST_NIBBLE,
                       lineSel: `BCH_RST_NIBBLE}; // see (R8) (R9) (R11) (R12)
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // Read data is captured in the setup cycle so it leaves a flip-flop.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setupPh && !pwrite) begin
            prdata_q <= rdMux;
        end
    end

    // Decoded window and line size, registered so consumers see clean flops.
    // They lag the fields by one cycle, which the datapath tolerates.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ioStart_q <= 32'h0000_0000;
            ioEnd_q   <= 32'h0000_0fff;
            lineDw_q  <= 6'h00;
        end else begin
            ioStart_q <= {16'h0000, cfg_q.ioBase, `BCH_IO_LOW_START}; // see (R11)
            ioEnd_q   <= {16'h0000, cfg_q.ioLimit, `BCH_IO_LOW_END}; // see (R12)
            lineDw_q  <= line_dwords(cfg_q.lineSel); // see (R3)
        end
    end

    // Identity dword reads back constant whatever was written.
    property p_ident_read;
        @(posedge sys_clk) disable iff (!resetn)
        (setupPh && !pwrite && hitIdent) |=> (prdata == {24'h060400, REV_CODE});
    endproperty
    a_ident_read: assert property (p_ident_read) // see (R1) (R2)
        else $error("Identity dword wrong.");

    // Line size follows bits 5:2 of a write and nothing else.
    property p_line_write;
        @(posedge sys_clk) disable iff (!resetn)
        (wrAccess && hitLine && pstrb[0]) |=> (cfg_q.lineSel == $past(pwdata[5:2]));
    endproperty
    a_line_write: assert property (p_line_write) // see (R3)
        else $error("Line size not written.");

    // Unsupported line size bits and the rest of dword 0Ch read constant.
    property p_line_read;
        @(posedge sys_clk) disable iff (!resetn)
        (setupPh && !pwrite && hitLine)
            |=> (prdata[1:0] == 2'h0) && (prdata[7:6] == 2'h0) && (prdata[31:8] == 24'h000100);
    endproperty
    a_line_read: assert property (p_line_read) // see (R4) (R5) (R6)
        else $error("Dword 0Ch constant bits wrong.");

    // Reserved offsets read zero.
    property p_rsvd_read;
        @(posedge sys_clk) disable iff (!resetn)
        (setupPh && !pwrite && (ofs == `BCH_OFS_RSVD_LO || ofs == `BCH_OFS_RSVD_HI))
            |=> (prdata == 32'h0000_0000);
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) // see (R7) (R13)
        else $error("Reserved offset not zero.");

    // Bus numbers land one cycle after the access edge.
    property p_bus_write;
        @(posedge sys_clk) disable iff (!resetn)
        (wrAccess && hitBus && pstrb[2:0] == 3'h7)
            |=> (busWord[23:0] == $past(pwdata[23:0]));
    endproperty
    a_bus_write: assert property (p_bus_write) // see (R8)
        else $error("Bus numbers not written.");

    // Secondary latency timer takes byte lane three.
    property p_lat_write;
        @(posedge sys_clk) disable iff (!resetn)
        (wrAccess && hitBus && pstrb[3]) |=> (cfg_q.secLatency == $past(pwdata[31:24]));
    endproperty
    a_lat_write: assert property (p_lat_write) // see (R9)
        else $error("Latency timer not written.");

    // I/O dword capability and reserved bits read constant.
    property p_io_read;
        @(posedge sys_clk) disable iff (!resetn)
        (setupPh && !pwrite && hitIo)
            |=> (prdata[3:0] == 4'h1) && (prdata[11:8] == 4'h1) && (prdata[31:16] == 16'h0);
    endproperty
    a_io_read: assert property (p_io_read) // see (R10)
        else $error("I/O capability bits wrong.");

    // Window start and end track the nibbles two cycles after a write.
    property p_io_window;
        @(posedge sys_clk) disable iff (!resetn)
        (wrAccess && hitIo && pstrb[1:0] == 2'h3)
            |=> ##1 (ioWindowStart == {16'h0, $past(pwdata[7:4], 2), 12'h000})
                 && (ioWindowEnd == {16'h0, $past(pwdata[15:12], 2), 12'hfff});
    endproperty
    a_io_window: assert property (p_io_window) // see (R11) (R12)
        else $error("I/O window not decoded.");

    // Writes outside the writable dwords leave every field untouched.
    property p_unmapped_write;
        @(posedge sys_clk) disable iff (!resetn)
        (wrAccess && !hitLine && !hitBus && !hitIo) |=> $stable(cfg_q);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) // see (R13)
        else $error("Stray write took effect.");

    // Line size bits of a read come from the field as it stood at the setup edge.
    property p_line_field_read;
        @(posedge sys_clk) disable iff (!resetn)
        (setupPh && !pwrite && hitLine) |=> (prdata[5:2] == $past(cfg_q.lineSel));
    endproperty
    a_line_field_read: assert property (p_line_field_read) // see (R3)
        else $error("Line size readback wrong.");

    // Bus number dword reads the four fields as they stood at the setup edge.
    property p_bus_field_read;
        @(posedge sys_clk) disable iff (!resetn)
        (setupPh && !pwrite && hitBus)
            |=> (prdata[7:0] == $past(cfg_q.primaryBus))
             && (prdata[15:8] == $past(cfg_q.secondaryBus))
             && (prdata[23:16] == $past(cfg_q.subordinateBus))
             && (prdata[31:24] == $past(cfg_q.secLatency));
    endproperty
    a_bus_field_read: assert property (p_bus_field_read) // see (R8) (R9)
        else $error("Bus number readback wrong.");

    // Window nibbles read back from the fields, not from the decoded outputs.
    property p_io_field_read;
        @(posedge sys_clk) disable iff (!resetn)
        (setupPh && !pwrite && hitIo)
            |=> (prdata[7:4] == $past(cfg_q.ioBase))
             && (prdata[15:12] == $past(cfg_q.ioLimit));
    endproperty
    a_io_field_read: assert property (p_io_field_read) // see (R11) (R12)
        else $error("I/O nibble readback wrong.");

    // Line size only moves through byte lane zero.
    property p_line_lane_keep;
        @(posedge sys_clk) disable iff (!resetn)
        (wrAccess && hitLine && !pstrb[0]) |=> $stable(cfg_q.lineSel);
    endproperty
    a_line_lane_keep: assert property (p_line_lane_keep) // see (R3)
        else $error("Line size moved without its lane.");

    // A line size write must not disturb any other field.
    property p_line_only;
        @(posedge sys_clk) disable iff (!resetn)
        (wrAccess && hitLine)
            |=> $stable(cfg_q.primaryBus) && $stable(cfg_q.secondaryBus)
             && $stable(cfg_q.subordinateBus) && $stable(cfg_q.secLatency)
             && $stable(cfg_q.ioBase) && $stable(cfg_q.ioLimit);
    endproperty
    a_line_only: assert property (p_line_only) // see (R13)
        else $error("Line size write touched another field.");

    // Each bus number byte moves only when its own lane is enabled.
    property p_bus_lane_keep;
        @(posedge sys_clk) disable iff (!resetn)
        (wrAccess && hitBus)
            |=> ($past(pstrb[0]) || $stable(cfg_q.primaryBus))
             && ($past(pstrb[1]) || $stable(cfg_q.secondaryBus))
             && ($past(pstrb[2]) || $stable(cfg_q.subordinateBus))
             && ($past(pstrb[3]) || $stable(cfg_q.secLatency))
             && $stable(cfg_q.lineSel) && $stable(cfg_q.ioBase) && $stable(cfg_q.ioLimit);
    endproperty
    a_bus_lane_keep: assert property (p_bus_lane_keep) // see (R8) (R9)
        else $error("Bus dword lane leaked.");

    // Window nibbles move only with their own lane, and nothing else moves.
    property p_io_lane_keep;
        @(posedge sys_clk) disable iff (!resetn)
        (wrAccess && hitIo)
            |=> ($past(pstrb[0]) || $stable(cfg_q.ioBase))
             && ($past(pstrb[1]) || $stable(cfg_q.ioLimit))
             && $stable(cfg_q.lineSel) && $stable(cfg_q.primaryBus)
             && $stable(cfg_q.secondaryBus) && $stable(cfg_q.subordinateBus)
             && $stable(cfg_q.secLatency);
    endproperty
    a_io_lane_keep: assert property (p_io_lane_keep) // see (R11) (R12) (R13)
        else $error("I/O dword lane leaked.");

    // Reset clears every field and registered output except ioWindowEnd, which loads 0FFFh; checked without a disable so it stays live.
    property p_reset_values;
        @(posedge sys_clk)
        !resetn |=> (cfg_q == '0) && (prdata == 32'h0000_0000)
                 && (ioWindowStart == 32'h0000_0000) && (ioWindowEnd == 32'h0000_0fff)
                 && (lineDwords == 6'h00);
    endproperty
    a_reset_values: assert property (p_reset_values) // see (R3) (R8) (R9) (R11) (R12)
        else $error("Reset values wrong.");

    // Read data only changes on a read setup, so writes cannot disturb it.
    property p_rdata_hold;
        @(posedge sys_clk) disable iff (!resetn)
        !(setupPh && !pwrite) |=> $stable(prdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) // see (R13)
        else $error("Read data moved outside a read.");

    // The largest selected size wins when software sets several bits.
    property p_line_top;
        @(posedge sys_clk) disable iff (!resetn)
        cfg_q.lineSel[3] |=> (lineDwords == 6'h20);
    endproperty
    a_line_top: assert property (p_line_top) // see (R3)
        else $error("Line size of 32 dwords not decoded.");

    // Bit 2 alone selects the smallest line.
    property p_line_four;
        @(posedge sys_clk) disable iff (!resetn)
        (cfg_q.lineSel == 4'h1) |=> (lineDwords == 6'h04);
    endproperty
    a_line_four: assert property (p_line_four) // see (R3)
        else $error("Line size of 4 dwords not decoded.");

    // No bit set means no line size, which consumers must treat as unset.
    property p_line_none;
        @(posedge sys_clk) disable iff (!resetn)
        (cfg_q.lineSel == 4'h0) |=> (lineDwords == 6'h00);
    endproperty
    a_line_none: assert property (p_line_none) // see (R3) (R4)
        else $error("Empty line size not decoded.");

    // Window start follows the base nibble one cycle later.
    property p_io_start_track;
        @(posedge sys_clk) disable iff (!resetn)
        1'b1 |=> (ioWindowStart == {16'h0000, $past(cfg_q.ioBase), 12'h000});
    endproperty
    a_io_start_track: assert property (p_io_start_track) // see (R11)
        else $error("Window start does not track.");

    // Window end follows the limit nibble one cycle later.
    property p_io_end_track;
        @(posedge sys_clk) disable iff (!resetn)
        1'b1 |=> (ioWindowEnd == {16'h0000, $past(cfg_q.ioLimit), 12'hfff});
    endproperty
    a_io_end_track: assert property (p_io_end_track) // see (R12)
        else $error("Window end does not track.");

endmodule

`default_nettype wire

//--- dv/bch_config_header_regs_tb_top.sv
// Self-checking bench for the bridge configuration header register slave.
// Assumes an APB slave on sys_clk that never signals an error.
`timescale 1ns/100ps
`default_nettype none

module bch_config_header_regs_tb_top;
    localparam logic [7:0] REV = 8'h5a; // Arbitrary value.
    logic              sys_clk = 1'b0;
    logic              resetn  = 1'b0;
    logic              psel    = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite  = 1'b0;
    logic [7:0]        paddr   = 8'h00;
    logic [31:0]       pwdata  = 32'h0;
    logic [3:0]        pstrb   = 4'h0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    bch_pkg::bch_cfg_s cfgOut;
    logic [31:0]       ioWindowStart;
    logic [31:0]       ioWindowEnd;
    logic [5:0]        lineDwords;
    logic [31:0]       expQ[$];
    logic [3:0]        lineM, baseM, limM;
    logic [31:0]       busM;
    logic [7:0]        addrs[8] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'hfc};
    integer            seed = 32'h61256fd5;
    int                err_total = 0;
    int                total_checks = 0;

    bch_config_header_regs #(.REV_CODE(REV), .ADDR_W(8)) uut (
        .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfgOut(cfgOut),
        .ioWindowStart(ioWindowStart), .ioWindowEnd(ioWindowEnd), .lineDwords(lineDwords));

    // Free-running 50 MHz clock.
    always #10 sys_clk = ~sys_clk;

    // Read image of each word, built from the shadow copy of the fields.
    function automatic logic [31:0] image(input logic [7:0] a);
        case (a)
            8'h08:   image = {8'h06, 8'h04, 8'h00, REV};
            8'h0c:   image = {8'h00, 1'b0, 7'h01, 8'h00, 2'b00, lineM, 2'b00};
            8'h18:   image = busM;
            8'h1c:   image = {16'h0, limM, 4'b0001, baseM, 4'b0001};
            default: image = 32'h0;
        endcase
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        if (!wr) expQ.push_back(image(a));
        @(posedge sys_clk);
        penable <= 1'b1;
        // If pready never rises, only the watchdog ends this wait.
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        // The shadow changes only once the write has been accepted.
        if (wr && a == 8'h0c && s[0]) lineM = d[5:2];
        if (wr && a == 8'h1c && s[0]) baseM = d[7:4];
        if (wr && a == 8'h1c && s[1]) limM = d[15:12];
        for (int i = 0; i < 4; i++) begin
            if (wr && a == 8'h18 && s[i]) busM[8*i +: 8] = d[8*i +: 8];
        end
    endtask

    // Reads are judged here, in the order they were issued.
    always @(posedge sys_clk) begin
        if (psel && penable && pready === 1'b1) begin
            check("pslverr", 32'h0000_0000, {31'h0, pslverr});
            if (!pwrite && expQ.size() > 0) begin
                check("prdata", expQ.pop_front(), prdata);
            end else if (!pwrite) begin
                check("readQueue", 32'h0000_0001, 32'h0000_0000);
            end
        end
    end

    task automatic do_reset();
        resetn <= 1'b0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        lineM = 4'h0;
        baseM = 4'h0;
        limM = 4'h0;
        busM = 32'h0;
        @(posedge sys_clk);
    endtask

    task automatic read_all();
        foreach (addrs[i]) apb(1'b0, addrs[i], 32'h0, 4'h0);
    endtask

    // Derived outputs lag the fields, so idle a cycle and look mid-cycle.
    task automatic check_outs();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
        check("ioWindowStart", {16'h0, baseM, 12'h000}, ioWindowStart);
        check("ioWindowEnd", {16'h0, limM, 12'hfff}, ioWindowEnd);
        check("lineDwords", lineM[3] ? 32 : lineM[2] ? 16 : lineM[1] ? 8 : lineM[0] ? 4 : 0,
              {26'h0, lineDwords});
        check("busFields", busM, {cfgOut.secLatency, cfgOut.subordinateBus,
              cfgOut.secondaryBus, cfgOut.primaryBus});
        @(posedge sys_clk);
    endtask

    task automatic end_of_test();
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Main sequence: reset values, read-only words, line sizes, random traffic, reset again.
    initial begin
        logic [31:0] d;
        logic [7:0]  a;
        do_reset();
        read_all();
        check_outs();
        for (int k = 0; k < 4; k++) apb(1'b1, 8'h08 + 8'(4 * k), 32'hffffffff, 4'hf);
        read_all();
        for (int b = 0; b < 5; b++) begin
            apb(1'b1, 8'h0c, {24'h0, 2'b11, 4'h1 << b, 2'b11}, 4'hf);
            apb(1'b0, 8'h0c, 32'h0, 4'h0);
            check_outs();
        end
        for (int k = 0; k < 40; k++) begin
            a = 8'h08 + 8'(4 * ($unsigned($random(seed)) % 7));
            d = $random(seed);
            apb(1'b1, a, d, 4'($random(seed)));
            apb(1'b0, a, 32'h0, 4'h0);
        end
        check_outs();
        do_reset();
        read_all();
        check_outs();
        end_of_test();
    end

    // Watchdog against a hung handshake.
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        end_of_test();
    end
endmodule

`default_nettype wire
